// File: rtl/pbs_port.sv
/*
 * Packet-buffer SRAM port: address, data and strobes to an external
 * SRAM, with the low address pins shared by the EEPROM autoload and the
 * upper pins lent to MII receive data in MII mode.
 * Assumes the bus grant comes from the host asynchronously and that the
 * internal requester holds its request until o_done.
 */
//
// Operation
// R1 - Grant low floats every buffer address output except pins 1..0, which autoload drives.
// R2 - MII mode turns address pins 19..16 into receive data inputs.
// R3 - After reset, autoload samples EEPROM serial data on address pin 2.
// R4 - During autoload, serial data to EEPROM goes out on address pin 1.
// R5 - During autoload, EEPROM shift clock goes out on address pin 0.
// R6 - After autoload, pins 2..0 return to address; 20-bit address.
// R7 - Bidirectional 16-bit buffer data bus.
// R8 - Read strobe low only during read accesses.
// R9 - Chip select low for every read or write access.
// R10 - Byte write enables low in writes; bit 1 high byte, bit 0 low.
// R11 - Raise request to get bus; host grants with acknowledge high.
// R12 - Grant low floats the whole buffer interface except address pins 1..0 during autoload.
// R13 - No access starts until autoload is finished.
`timescale 1ns/1ps
module pbs_port
	import pbs_pkg::*;
(
	input  wire logic                       i_clk_sys,
	input  wire logic                       i_rst,
	input  wire logic                       i_mii_mode,
	input  wire logic                       i_bus_grant_ack,
	output logic                            o_bus_request,
	input  wire logic                       i_req,
	input  wire logic                       i_write,
	input  wire logic [pbs_pkg::ADDR_W-1:0] i_addr,
	input  wire logic [pbs_pkg::DATA_W-1:0] i_wdata,
	input  wire logic [1:0]                 i_byte_en,
	output logic                            o_done,
	output logic [pbs_pkg::DATA_W-1:0]      o_rdata,
	output logic [pbs_pkg::RXD_W-1:0]       o_mii_rxd,
	output logic                            o_load_busy,
	output logic                            o_cfg_valid,
	output logic [pbs_pkg::DATA_W-1:0]      o_cfg_word,
	input  wire logic [pbs_pkg::ADDR_W-1:0] i_buffer_addr,
	output logic [pbs_pkg::ADDR_W-1:0]      o_buffer_addr,
	output logic [pbs_pkg::ADDR_W-1:0]      o_buffer_addr_oe,
	input  wire logic [pbs_pkg::DATA_W-1:0] i_buffer_data,
	output logic [pbs_pkg::DATA_W-1:0]      o_buffer_data,
	output logic                            o_buffer_data_oe,
	output logic                            o_buffer_select_n,
	output logic                            o_buffer_select_n_oe,
	output logic                            o_buffer_read_strobe_n,
	output logic                            o_buffer_read_strobe_n_oe,
	output logic [1:0]                      o_buffer_byte_write_n,
	output logic [1:0]                      o_buffer_byte_write_n_oe
);
	import pbs_pkg::*;

	pbs_state_type           state_r;
	logic [1:0]              gnt_sync_r;
	logic [1:0]              do_sync_r;
	logic [RXD_W-1:0]        rxd_s1_r;
	logic [RXD_W-1:0]        rxd_s2_r;
	logic                    granted;
	logic                    ee_do;
	logic                    ee_di;
	logic                    ee_ck;
	logic                    ld_busy;
	logic [ADDR_W-1:0]       addr_r;
	logic [DATA_W-1:0]       wdata_r;
	logic                    wr_r;
	logic [1:0]              be_r;
	logic                    take;

	assign granted = gnt_sync_r[1];
	assign ee_do = do_sync_r[1];
	assign o_load_busy = ld_busy;

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	// Grant comes from the host's clock; two flops before any use
	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
			gnt_sync_r <= '0;
		else
			gnt_sync_r <= {gnt_sync_r[0], i_bus_grant_ack};
	end

	// The EEPROM answers on its own clock edges, not on ours
	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
			do_sync_r <= '0;
		else
			do_sync_r <= {do_sync_r[0], i_buffer_addr[EE_DO_B]}; // R3
	end

	// Receive nibble comes from the external transceiver's clock
	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
		begin
			rxd_s1_r <= '0;
			rxd_s2_r <= '0;
		end
		else
		begin
			rxd_s1_r <= i_buffer_addr[RXD_LSB +: RXD_W];
			rxd_s2_r <= rxd_s1_r;
		end
	end

	// Pin 19 carries RXD0, so the nibble is bit-reversed
	always_comb
	begin
		for (int k = 0; k < RXD_W; k++)
			o_mii_rxd[k] = rxd_s2_r[RXD_W-1-k]; // R2
	end

	// ----------------------------------------------------------------
	// EEPROM autoload
	// ----------------------------------------------------------------
	pbs_ee_loader pbs_ee_loader_i (
		.i_clk_sys            (i_clk_sys),
		.i_rst                (i_rst),
		.i_eeprom_serial_in   (ee_do),
		.o_eeprom_serial_out  (ee_di),
		.o_eeprom_shift_clock (ee_ck),
		.o_busy               (ld_busy),
		.o_word_valid         (o_cfg_valid),
		.o_word               (o_cfg_word)
	);

	// ----------------------------------------------------------------
	// Access sequencer: one cycle of strobes per access, then done
	// ----------------------------------------------------------------
	assign take = state_r == PBS_IDLE && i_req && granted
		&& !ld_busy; // R13

	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
			state_r <= PBS_IDLE;
		else
		begin
			unique case (state_r)
				PBS_IDLE:
					if (take)
						state_r <= PBS_ACCESS;
				PBS_ACCESS:
					state_r <= PBS_DONE;
				PBS_DONE:
					state_r <= PBS_IDLE;
			endcase
		end
	end

	// Request is latched at the take so the pins hold still for the access
	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
		begin
			addr_r <= '0;
			wdata_r <= '0;
			wr_r <= 1'b0;
			be_r <= '0;
		end
		else if (take)
		begin
			addr_r <= i_addr;
			wdata_r <= i_wdata;
			wr_r <= i_write;
			be_r <= i_byte_en;
		end
	end

	// SRAM read data is captured at the end of the strobe cycle
	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
			o_rdata <= '0;
		else if (state_r == PBS_ACCESS && !wr_r)
			o_rdata <= i_buffer_data;
	end

	assign o_done = (state_r == PBS_DONE);
	assign o_bus_request = i_req && !ld_busy; // R11

	// ----------------------------------------------------------------
	// Pin drive; strobes idle high, all but autoload pins 1..0 float without grant
	// ----------------------------------------------------------------
	always_comb
	begin
		o_buffer_addr = addr_r;
		o_buffer_addr_oe = {ADDR_W{granted}}; // R1 R12
		if (ld_busy)
		begin
			o_buffer_addr[EE_DI_B] = ee_di; // R4
			o_buffer_addr[EE_CK_B] = ee_ck; // R5
			o_buffer_addr_oe[EE_DO_B] = 1'b0; // R3
			o_buffer_addr_oe[EE_DI_B] = 1'b1; // R4
			o_buffer_addr_oe[EE_CK_B] = 1'b1; // R5
		end
		if (i_mii_mode)
			o_buffer_addr_oe[ADDR_MSB -: RXD_W] = '0; // R2
	end

	// One lane's write enable: low only in a write access with that lane on
	function automatic logic lane_write_n(
		input pbs_state_type st,
		input logic          wr,
		input logic          en
	);
		return !(st == PBS_ACCESS && wr && en);
	endfunction : lane_write_n

	always_comb
	begin
		o_buffer_select_n = !(state_r == PBS_ACCESS); // R9
		o_buffer_read_strobe_n = !(state_r == PBS_ACCESS && !wr_r); // R8
		o_buffer_byte_write_n[HI_LANE] =
			lane_write_n(state_r, wr_r, be_r[HI_LANE]); // R10
		o_buffer_byte_write_n[LO_LANE] =
			lane_write_n(state_r, wr_r, be_r[LO_LANE]); // R10
		o_buffer_data = wdata_r; // R7
		o_buffer_data_oe = granted && state_r == PBS_ACCESS && wr_r; // R7
		o_buffer_select_n_oe = granted; // R12
		o_buffer_read_strobe_n_oe = granted; // R12
		o_buffer_byte_write_n_oe = {2{granted}}; // R12
	end
endmodule : pbs_port

// File: rtl/pbs_pkg.sv
/*
 * Constants shared by the packet-buffer SRAM port and its EEPROM loader.
 * Assumes a single 25 MHz system clock and an asynchronous high reset.
 */
package pbs_pkg;
	// ----------------------------------------------------------------
	// Widths and pin positions
	// ----------------------------------------------------------------
	localparam int ADDR_W   = 20;
	localparam int DATA_W   = 16;
	localparam int ADDR_MSB = 19;
	localparam int RXD_LSB  = 16;
	localparam int RXD_W    = 4;
	localparam int EE_DO_B  = 2;
	localparam int EE_DI_B  = 1;
	localparam int EE_CK_B  = 0;
	localparam int EE_W     = 3;
	localparam int HI_LANE  = 1;
	localparam int LO_LANE  = 0;

	// ----------------------------------------------------------------
	// Loader timing and sizes
	// ----------------------------------------------------------------
	localparam int EE_CK_HALF = 4;
	localparam int EE_CMD_W   = 11;
	localparam int EE_WORDS   = 8;
	localparam logic [EE_CMD_W-1:0] EE_CMD_READ = 11'h600;

	// ----------------------------------------------------------------
	// Port states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		PBS_IDLE,
		PBS_ACCESS,
		PBS_DONE
	} pbs_state_type;
endpackage : pbs_pkg

// File: rtl/pbs_ee_loader.sv
/*
 * Serial EEPROM autoload engine: sends a read command and shifts in a
 * fixed number of 16-bit words after reset, then reports done.
 * Assumes the data-out pin is already synchronised by the caller.
 */
`timescale 1ns/1ps
module pbs_ee_loader
	import pbs_pkg::*;
#(
	parameter int WORDS = EE_WORDS
)(
	input  wire logic              i_clk_sys,
	input  wire logic              i_rst,
	input  wire logic              i_eeprom_serial_in,
	output logic                   o_eeprom_serial_out,
	output logic                   o_eeprom_shift_clock,
	output logic                   o_busy,
	output logic                   o_word_valid,
	output logic [DATA_W-1:0]      o_word
);
	import pbs_pkg::*;

	localparam int TOT   = EE_CMD_W + WORDS * DATA_W;
	localparam int DIV_W = $clog2(EE_CK_HALF);
	localparam int BIT_W = $clog2(TOT + 1);

	logic [DIV_W-1:0]              div_r;
	logic [BIT_W-1:0]              bit_r;
	logic [EE_CMD_W-1:0]           cmd_r;
	logic [$clog2(DATA_W)-1:0]     bcnt_r;
	logic                          half_end;
	logic                          rise;
	logic                          fall;

	assign half_end = div_r == DIV_W'(EE_CK_HALF - 1);
	assign rise = o_busy && !o_eeprom_shift_clock && half_end;
	assign fall = o_busy && o_eeprom_shift_clock && half_end;

	// ----------------------------------------------------------------
	// Shift clock divider; stops once the load completes
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
		begin
			div_r <= '0;
			o_eeprom_shift_clock <= 1'b0;
		end
		else if (!o_busy)
			o_eeprom_shift_clock <= 1'b0; // R5
		else if (half_end)
		begin
			div_r <= '0;
			o_eeprom_shift_clock <= ~o_eeprom_shift_clock; // R5
		end
		else
			div_r <= div_r + 1'b1;
	end

	// ----------------------------------------------------------------
	// Bit sequencing: command out, then data in on rising edges
	// ----------------------------------------------------------------
	// Command bits change on the falling edge, so each one has half a
	// period of setup before the EEPROM samples it on the rise
	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
		begin
			cmd_r <= {EE_CMD_READ[EE_CMD_W-2:0], 1'b0};
			o_eeprom_serial_out <= EE_CMD_READ[EE_CMD_W-1];
		end
		else if (fall)
		begin
			o_eeprom_serial_out <= cmd_r[EE_CMD_W-1]; // R4
			cmd_r <= {cmd_r[EE_CMD_W-2:0], 1'b0};
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_busy <= 1'b1;
			bit_r <= '0;
			bcnt_r <= '0;
			o_word <= '0;
			o_word_valid <= 1'b0;
		end
		else
		begin
			o_word_valid <= 1'b0;
			if (rise)
			begin
				if (bit_r >= BIT_W'(EE_CMD_W))
				begin
					// R3
					o_word <= {o_word[DATA_W-2:0], i_eeprom_serial_in};
					bcnt_r <= bcnt_r + 1'b1;
					o_word_valid <= (bcnt_r == '1);
				end
				if (bit_r == BIT_W'(TOT - 1))
					o_busy <= 1'b0; // R6
				bit_r <= bit_r + 1'b1;
			end
		end
	end
endmodule : pbs_ee_loader

// File: verif/pbs_port_checker.sv
/* Pin-level assertions for the packet-buffer SRAM port.
   Assumes one clock domain and an asynchronous high reset. */
`timescale 1ns/1ps
module pbs_port_checker
	import pbs_pkg::*;
(
	input wire logic              i_clk_sys,
	input wire logic              i_rst,
	input wire logic              i_mii_mode,
	input wire logic              i_bus_grant_ack,
	input wire logic              i_req,
	input wire logic              o_bus_request,
	input wire logic              o_done,
	input wire logic              o_load_busy,
	input wire logic [ADDR_W-1:0] o_buffer_addr_oe,
	input wire logic              o_buffer_data_oe,
	input wire logic              o_buffer_select_n,
	input wire logic              o_buffer_select_n_oe,
	input wire logic              o_buffer_read_strobe_n,
	input wire logic [1:0]        o_buffer_byte_write_n
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);
	sequence s_access;
		!o_buffer_select_n ##1 (o_done && o_buffer_select_n);
	endsequence
	// Grant passes a two-flop sync, so allow the lag
	property p_float;
		!i_bus_grant_ack [*4] |-> o_buffer_addr_oe[ADDR_W-1:EE_W] == '0
			&& !o_buffer_select_n_oe && !o_buffer_data_oe;
	endproperty
	a_float: assert property (p_float) else $error("drives ungranted");
	property p_mii;
		i_mii_mode [*4] |-> o_buffer_addr_oe[ADDR_MSB:RXD_LSB] == 4'h0;
	endproperty
	a_mii: assert property (p_mii) else $error("drives rxd pins");
	property p_eein;
		o_load_busy |-> !o_buffer_addr_oe[EE_DO_B];
	endproperty
	a_eein: assert property (p_eein) else $error("drives pin 2");
	property p_eeout;
		o_load_busy [*2] |-> o_buffer_addr_oe[EE_DI_B:EE_CK_B] == 2'h3;
	endproperty
	a_eeout: assert property (p_eeout) else $error("pins 1/0 idle");
	property p_addr;
		!o_buffer_select_n |-> &o_buffer_addr_oe[RXD_LSB-1:0];
	endproperty
	a_addr: assert property (p_addr) else $error("address floats");
	property p_wr;
		o_buffer_byte_write_n != 2'h3 |-> o_buffer_data_oe
			&& !o_buffer_select_n && o_buffer_read_strobe_n;
	endproperty
	a_wr: assert property (p_wr) else $error("bad write");
	property p_rd;
		!o_buffer_read_strobe_n |-> !o_buffer_select_n
			&& o_buffer_byte_write_n == 2'h3 && !o_buffer_data_oe;
	endproperty
	a_rd: assert property (p_rd) else $error("bad read");
	property p_acc;
		!o_buffer_select_n |-> s_access;
	endproperty
	a_acc: assert property (p_acc) else $error("bad access");
	property p_done;
		o_done |-> !$past(o_buffer_select_n);
	endproperty
	a_done: assert property (p_done) else $error("stray done");
	property p_req;
		i_req && !o_load_busy |-> o_bus_request;
	endproperty
	a_req: assert property (p_req) else $error("no request");
	property p_load;
		o_load_busy |-> o_buffer_select_n && !o_bus_request
			&& o_buffer_byte_write_n == 2'h3;
	endproperty
	a_load: assert property (p_load) else $error("access in load");
endmodule : pbs_port_checker
bind pbs_port pbs_port_checker pbs_port_checker_i (.*);

// File: verif/pbs_sram_model.sv
/* Behavioural SRAM (16 words) and serial EEPROM on the shared pins.
   Assumes the bench resolves every pin from all drivers. */
`timescale 1ns/1ps
module pbs_sram_model
	import pbs_pkg::*;
(
	input  wire logic [ADDR_W-1:0] i_addr,
	input  wire logic [DATA_W-1:0] i_data,
	input  wire logic              i_clk_sys,
	input  wire logic              i_sel_n,
	input  wire logic              i_rd_n,
	input  wire logic [1:0]        i_wr_n,
	output logic [DATA_W-1:0]      o_data,
	output logic                   o_ee_do,
	output logic [EE_CMD_W-1:0]    o_cmd
);
	localparam logic [DATA_W-1:0] EE_WORD = 16'hC35A;
	localparam int LAST = EE_CMD_W + EE_WORDS * DATA_W;
	logic [DATA_W-1:0] mem [16];
	int                rises = 0;
	int                bi;
	initial o_cmd = '0;
	always @(posedge i_addr[EE_CK_B])
		if (rises <= LAST)
		begin
			if (rises < EE_CMD_W)
				o_cmd <= {o_cmd[EE_CMD_W-2:0], i_addr[EE_DI_B]};
			rises <= rises + 1;
		end
	// Data changes on the falling edge; released line reads pull-down
	always @(negedge i_addr[EE_CK_B])
	begin
		bi = rises - EE_CMD_W;
		o_ee_do <= (bi >= 0 && bi < LAST - EE_CMD_W) ?
			EE_WORD[DATA_W-1-bi%DATA_W] : 1'b0;
	end
	assign o_data = (!i_sel_n && !i_rd_n) ? mem[i_addr[3:0]] : '0;
	always @(posedge i_clk_sys)
		if (!i_sel_n)
		begin
			if (!i_wr_n[HI_LANE])
				mem[i_addr[3:0]][15:8] <= i_data[15:8];
			if (!i_wr_n[LO_LANE])
				mem[i_addr[3:0]][7:0] <= i_data[7:0];
		end
endmodule : pbs_sram_model

// File: verif/tb_packet_buffer_sram_port.sv
/* Self-checking bench for the SRAM port with SRAM/EEPROM model.
   Assumes a 25 MHz clock; inputs change 1 ns after each rising edge. */
`timescale 1ns/1ps
module tb_packet_buffer_sram_port;
	import pbs_pkg::*;
	logic               clk, rst = 1, mii = 0, gnt = 1, req = 0, wr = 0;
	logic [1:0]         be = 0, bw_n, bw_oe;
	logic [ADDR_W-1:0]  addr = 0, pin_a, o_a, a_oe;
	logic [DATA_W-1:0]  wd = 0, rd, cfg, pin_d, o_d, m_d;
	logic [RXD_W-1:0]   rxd = 0, mrx;
	logic [EE_CMD_W-1:0] cmd;
	logic  breq, done, busy, cv, d_oe, sel_n, sel_oe, rs_n, rs_oe, ee_do;
	int    fail_count = 0, n_checks = 0, cyc = 0, nv = 0;
	assign pin_a = (a_oe & o_a) | (~a_oe & {rxd, 13'h0, ee_do, 2'h0});
	assign pin_d = d_oe ? o_d : m_d;
	pbs_port pbs_port_i (.i_clk_sys(clk), .i_rst(rst), .i_mii_mode(mii),
		.i_bus_grant_ack(gnt), .o_bus_request(breq), .i_req(req),
		.i_write(wr), .i_addr(addr), .i_wdata(wd), .i_byte_en(be),
		.o_done(done), .o_rdata(rd), .o_mii_rxd(mrx), .o_load_busy(busy),
		.o_cfg_valid(cv), .o_cfg_word(cfg), .i_buffer_addr(pin_a),
		.o_buffer_addr(o_a), .o_buffer_addr_oe(a_oe), .i_buffer_data(pin_d),
		.o_buffer_data(o_d), .o_buffer_data_oe(d_oe),
		.o_buffer_select_n(sel_n), .o_buffer_select_n_oe(sel_oe),
		.o_buffer_read_strobe_n(rs_n), .o_buffer_read_strobe_n_oe(rs_oe),
		.o_buffer_byte_write_n(bw_n), .o_buffer_byte_write_n_oe(bw_oe));
	pbs_sram_model pbs_sram_model_i (.i_addr(pin_a), .i_data(pin_d),
		.i_clk_sys(clk), .i_sel_n(sel_oe ? sel_n : 1'b1),
		.i_rd_n(rs_oe ? rs_n : 1'b1), .i_wr_n(bw_oe ? bw_n : 2'h3),
		.o_data(m_d), .o_ee_do(ee_do), .o_cmd(cmd));
	initial
	begin
		clk = 0;
		forever #20 clk = ~clk;
	end
	task tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	task tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : tally_and_finish
	always @(posedge clk)
		if (++cyc == 5000)
		begin
			fail_count++;
			tally_and_finish();
		end
	task chk(input logic [ADDR_W-1:0] got, input logic [ADDR_W-1:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Holds the request until done, which stands for one cycle
	task acc(input logic w, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d, input logic [1:0] b);
		int n;
		n = 0;
		{wr, addr, wd, be, req} = {w, a, d, b, 1'b1};
		while (done !== 1'b1 && n < 20)
		begin
			tick(1);
			n++;
		end
		req = 0;
		tick(1);
		chk(n < 20, 1);
	endtask : acc
	task t_load;
		int nd;
		nd = 0;
		req = 1;
		while (busy !== 1'b0 && cyc < 3000)
		begin
			tick(1);
			nv += (cv === 1'b1);
			nd += (busy === 1'b1 && (done !== 1'b0 || breq !== 1'b0));
		end
		req = 0;
		tick(1);
		chk(nd, 0);
		chk(nv, EE_WORDS);
		chk(cfg, 16'hC35A);
		chk(cmd, EE_CMD_READ);
		$display("load test done");
	endtask : t_load
	task t_rw;
		acc(1, 20'hABCD5, 16'h1234, 2'h3);
		acc(1, 20'hABCD5, 16'hAB99, 2'h2);
		acc(1, 20'h00006, 16'h5566, 2'h3);
		acc(1, 20'h00006, 16'h0077, 2'h1);
		acc(0, 20'hABCD5, 16'h0, 2'h0);
		chk(rd, 16'hAB34);
		acc(0, 20'h00006, 16'h0, 2'h0);
		chk(rd, 16'h5577);
		$display("read write test done");
	endtask : t_rw
	task t_float;
		int nd;
		nd = 0;
		gnt = 0;
		tick(4);
		chk(a_oe, '0);
		chk({sel_oe, rs_oe, bw_oe, d_oe}, 0);
		{wr, req} = 2'h1;
		repeat (10)
		begin
			tick(1);
			nd += (done !== 1'b0);
		end
		chk(nd, 0);
		chk(breq, 1);
		gnt = 1;
		acc(0, 20'hABCD5, 16'h0, 2'h0);
		chk(rd, 16'hAB34);
		$display("float test done");
	endtask : t_float
	task t_mii;
		mii = 1;
		rxd = 4'hC;
		tick(4);
		chk(mrx, 4'h3);
		chk(a_oe[ADDR_MSB:RXD_LSB], 0);
		mii = 0;
		rxd = 0;
		$display("mii test done");
	endtask : t_mii
	initial
	begin
		tick(3);
		rst = 0;
		t_load();
		t_rw();
		t_float();
		t_mii();
		tally_and_finish();
	end
endmodule : tb_packet_buffer_sram_port
